// ===== core/status_byte_service_request.v
// status byte, service request and command completion logic
`timescale 1ns/1ps
`include "status_byte_defines.vh"
module status_byte_service_request (
    input wire clk_sys_i,
    input wire rst_i,
    input wire [`GRP_W-1:0] operation_summary_event_set_i,
    input wire [`GRP_W-1:0] operation_summary_enable_i,
    input wire operation_summary_event_read_i,
    input wire [`GRP_W-1:0] ques_event_set_i,
    input wire [`GRP_W-1:0] ques_enable_i,
    input wire ques_event_read_i,
    input wire [`ESR_W-1:0] std_event_set_i,
    input wire [`ESR_W-1:0] std_enable_i,
    input wire std_event_read_i,
    input wire [7:0] srq_enable_i,
    input wire stb_query_i,
    input wire serial_poll_i,
    input wire [2:0] cmd_i,
    input wire cmd_valid_i,
    input wire cmd_parallel_i,
    input wire cmd_done_i,
    input wire par_busy_i,
    input wire trans_busy_i,
    input wire [1:0] trigger_state_query_i,
    input wire trig_query_i,
    input wire resp_wr_i,
    input wire [7:0] resp_data_i,
    input wire oq_rd_i,
    output reg [7:0] status_resp_o,
    output reg status_resp_valid_o,
    output reg srq_o,
    output reg [`GRP_W-1:0] operation_summary_event_o,
    output reg [`GRP_W-1:0] ques_event_o,
    output reg [`ESR_W-1:0] std_event_o,
    output reg [7:0] oq_data_o,
    output reg oq_data_valid_o,
    output reg message_available_o,
    output reg cmd_ready_o,
    output reg [1:0] trigger_state_o,
    output reg trigger_state_valid_o
);
    localparam S_RUN = `ST_RUN;
    localparam S_WAIT = `ST_WAIT;
    localparam S_OPCQ = `ST_OPCQ;

    reg [`GRP_W-1:0] operation_summary_ev_r;
    reg [`GRP_W-1:0] ques_ev_r;
    reg [`ESR_W-1:0] std_ev_r;
    reg request_service_latch_r;
    reg master_summary_q_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg opc_pending_r;
    reg seq_busy_r;
    reg [7:0] stb_base;
    reg master_summary;
    reg opc_set;
    reg opc_wr;
    wire [7:0] oq_rdata;
    wire oq_empty;
    wire oq_full;
    wire oq_wr;
    wire all_done;
    wire nontrans_done;
    wire cmd_take;

    // a read clears the register, but a set in the same cycle survives
    function [`GRP_W-1:0] ev_next;
        input [`GRP_W-1:0] cur;
        input [`GRP_W-1:0] set;
        input rd;
        begin
            ev_next = (rd ? {`GRP_W{1'b0}} : cur) | set;
        end
    endfunction

    always @*
    begin
        stb_base = `SB_RESET;
        stb_base[`SB_OPERATION_SUMMARY_BIT] = |(operation_summary_ev_r & operation_summary_enable_i);
        stb_base[`SB_QUES_BIT] = |(ques_ev_r & ques_enable_i);
        stb_base[`SB_ESB_BIT] = |(std_ev_r & std_enable_i);
        stb_base[`SB_MAV_BIT] = ~oq_empty;
        master_summary = |(stb_base & srq_enable_i);
    end

    assign all_done = ~seq_busy_r & ~par_busy_i & ~trans_busy_i;
    assign nontrans_done = ~seq_busy_r & ~par_busy_i;
    assign cmd_take = cmd_valid_i & cmd_ready_o;

    always @*
    begin
        state_nxt = state_r;
        opc_wr = 1'b0;
        case (state_r)
            S_RUN:
            begin
                if (cmd_take && cmd_i == `CMD_WAI)
                begin
                    state_nxt = S_WAIT;
                end
                else if (cmd_take && cmd_i == `CMD_OPCQ)
                begin
                    state_nxt = S_OPCQ;
                end
            end
            S_WAIT:
            begin
                if (nontrans_done)
                begin
                    state_nxt = S_RUN;
                end
            end
            S_OPCQ:
            begin
                // the answer must not be lost to a full queue
                if (all_done && !oq_full)
                begin
                    opc_wr = 1'b1;
                    state_nxt = S_RUN;
                end
            end
            default:
            begin
                state_nxt = S_RUN;
            end
        endcase
        opc_set = opc_pending_r & all_done;
    end

    assign oq_wr = opc_wr | (resp_wr_i & ~opc_wr);

    output_queue u_oq (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_i(oq_wr),
        .wr_data_i(opc_wr ? `OPC_ONE_CHAR : resp_data_i),
        .rd_i(oq_rd_i),
        .rd_data_o(oq_rdata),
        .empty_o(oq_empty),
        .full_o(oq_full)
    );

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            operation_summary_ev_r <= {`GRP_W{1'b0}};
            ques_ev_r <= {`GRP_W{1'b0}};
            std_ev_r <= {`ESR_W{1'b0}};
            request_service_latch_r <= 1'b0;
            master_summary_q_r <= 1'b0;
            srq_o <= 1'b0;
            state_r <= S_RUN;
            opc_pending_r <= 1'b0;
            seq_busy_r <= 1'b0;
            status_resp_o <= 8'h00;
            status_resp_valid_o <= 1'b0;
            operation_summary_event_o <= {`GRP_W{1'b0}};
            ques_event_o <= {`GRP_W{1'b0}};
            std_event_o <= {`ESR_W{1'b0}};
            oq_data_o <= 8'h00;
            oq_data_valid_o <= 1'b0;
            message_available_o <= 1'b0;
            cmd_ready_o <= 1'b0;
            trigger_state_o <= `TRIG_IDLE;
            trigger_state_valid_o <= 1'b0;
        end
        else
        begin
            operation_summary_ev_r <= ev_next(operation_summary_ev_r, operation_summary_event_set_i,
                operation_summary_event_read_i);
            ques_ev_r <= ev_next(ques_ev_r, ques_event_set_i,
                ques_event_read_i);
            std_ev_r <= (std_event_read_i ? {`ESR_W{1'b0}} : std_ev_r)
                | std_event_set_i
                | {{(`ESR_W-1){1'b0}}, opc_set};
            operation_summary_event_o <= operation_summary_ev_r;
            ques_event_o <= ques_ev_r;
            std_event_o <= std_ev_r;
            master_summary_q_r <= master_summary;
            // rising master summary wins over a poll in the same cycle
            if (master_summary & ~master_summary_q_r)
            begin
                request_service_latch_r <= 1'b1;
                srq_o <= 1'b1;
            end
            else if (serial_poll_i)
            begin
                request_service_latch_r <= 1'b0;
                srq_o <= 1'b0;
            end
            status_resp_valid_o <= stb_query_i | serial_poll_i;
            if (serial_poll_i)
            begin
                status_resp_o <= {stb_base[7], request_service_latch_r,
                    stb_base[5:0]};
            end
            else if (stb_query_i)
            begin
                status_resp_o <= {stb_base[7], master_summary,
                    stb_base[5:0]};
            end
            message_available_o <= ~oq_empty;
            oq_data_valid_o <= oq_rd_i & ~oq_empty;
            if (oq_rd_i & ~oq_empty)
            begin
                oq_data_o <= oq_rdata;
            end
            // a sequential CMD_NONE command holds the queue of commands until done
            if (cmd_take && !cmd_parallel_i && cmd_i == `CMD_NONE)
            begin
                seq_busy_r <= 1'b1;
            end
            else if (cmd_done_i)
            begin
                seq_busy_r <= 1'b0;
            end
            if (cmd_take && cmd_i == `CMD_OPC)
            begin
                opc_pending_r <= 1'b1;
            end
            else if (opc_set)
            begin
                opc_pending_r <= 1'b0;
            end
            state_r <= state_nxt;
            cmd_ready_o <= (state_nxt == S_RUN) & ~seq_busy_r
                & ~(cmd_take && !cmd_parallel_i
                && cmd_i == `CMD_NONE);
            trigger_state_valid_o <= trig_query_i;
            if (trig_query_i)
            begin
                // an unknown code reports busy, never a fourth value
                trigger_state_o <= (trigger_state_query_i == `TRIG_IDLE ||
                    trigger_state_query_i == `TRIG_ARMED) ? trigger_state_query_i
                    : `TRIG_BUSY;
            end
        end
    end
endmodule // status_byte_service_request

// ===== core/status_byte_defines.vh
// bit positions, widths and codes shared by the status byte logic
`ifndef STATUS_BYTE_DEFINES_VH
`define STATUS_BYTE_DEFINES_VH
`define SB_QUES_BIT 3
`define SB_MAV_BIT 4
`define SB_ESB_BIT 5
`define SB_MSS_BIT 6
`define SB_OPERATION_SUMMARY_BIT 7
`define SB_RESET 8'h00
`define GRP_W 16
`define ESR_W 8
`define ESR_OPC_BIT 0
`define OQ_DEPTH 16
`define OQ_AW 4
`define OQ_CW 5
`define OPC_ONE_CHAR 8'h31
`define TRIG_IDLE 2'h0
`define TRIG_ARMED 2'h1
`define TRIG_BUSY 2'h2
`define CMD_NONE 3'h0
`define CMD_WAI 3'h1
`define CMD_OPC 3'h2
`define CMD_OPCQ 3'h3
`define ST_RUN 2'h0
`define ST_WAIT 2'h1
`define ST_OPCQ 2'h2
`endif

// ===== core/output_queue.v
// first-in first-out queue for response bytes bound for the controller
`timescale 1ns/1ps
`include "status_byte_defines.vh"
module output_queue (
    input wire clk_sys_i,
    input wire rst_i,
    input wire wr_i,
    input wire [7:0] wr_data_i,
    input wire rd_i,
    output wire [7:0] rd_data_o,
    output wire empty_o,
    output wire full_o
);
    reg [7:0] mem_r [0:`OQ_DEPTH-1];
    reg [`OQ_AW-1:0] wp_r;
    reg [`OQ_AW-1:0] rp_r;
    reg [`OQ_CW-1:0] cnt_r;
    wire do_wr;
    wire do_rd;
    assign empty_o = (cnt_r == {`OQ_CW{1'b0}});
    assign full_o = (cnt_r == `OQ_DEPTH);
    assign do_rd = rd_i & ~empty_o;
    // a full queue still accepts a write when a read frees a slot
    assign do_wr = wr_i & (~full_o | do_rd);
    assign rd_data_o = mem_r[rp_r];
    always @(posedge clk_sys_i)
    begin
        if (do_wr)
        begin
            mem_r[wp_r] <= wr_data_i;
        end
    end
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_r <= {`OQ_AW{1'b0}};
            rp_r <= {`OQ_AW{1'b0}};
            cnt_r <= {`OQ_CW{1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wp_r <= wp_r + 1'b1;
            end
            if (do_rd)
            begin
                rp_r <= rp_r + 1'b1;
            end
            if (do_wr & ~do_rd)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (do_rd & ~do_wr)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // output_queue

// ===== test/bus_ctrl_model.sv
// bus controller model issuing status queries and serial polls
`timescale 1ns/1ps
module bus_ctrl_model (
    input wire clk_sys_i,
    input wire [7:0] status_resp_i,
    input wire status_resp_valid_i,
    output reg serial_poll_o,
    output reg stb_query_o
);
initial
begin
    serial_poll_o = 1'b0;
    stb_query_o = 1'b0;
end
// answer taken only in the cycle its valid stands, else unknown
task ask(input poll, output [7:0] resp);
begin
    @(negedge clk_sys_i);
    serial_poll_o = poll;
    stb_query_o = ~poll;
    @(negedge clk_sys_i);
    serial_poll_o = 1'b0;
    stb_query_o = 1'b0;
    resp = status_resp_valid_i ? status_resp_i : 8'hXX;
end
endtask
endmodule // bus_ctrl_model

// ===== test/status_byte_chk.sv
// port assertions for the status byte and service request block
`timescale 1ns/1ps
`include "status_byte_defines.vh"
module status_byte_chk (
    input wire clk_sys_i,
    input wire rst_i,
    input wire stb_query_i,
    input wire serial_poll_i,
    input wire operation_summary_event_read_i,
    input wire [`GRP_W-1:0] operation_summary_event_set_i,
    input wire [2:0] cmd_i,
    input wire cmd_valid_i,
    input wire cmd_parallel_i,
    input wire cmd_done_i,
    input wire [1:0] trigger_state_query_i,
    input wire trig_query_i,
    input wire [7:0] status_resp_o,
    input wire status_resp_valid_o,
    input wire srq_o,
    input wire [`GRP_W-1:0] operation_summary_event_o,
    input wire oq_rd_i,
    input wire oq_data_valid_o,
    input wire cmd_ready_o,
    input wire [1:0] trigger_state_o,
    input wire trigger_state_valid_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
a_query_answer: assert property (stb_query_i |=> status_resp_valid_o)
    else $error("status query not answered");
a_query_keeps_srq: assert property (stb_query_i && !serial_poll_i && srq_o
    |=> srq_o)
    else $error("query disturbed service request");
a_answer_cause: assert property (status_resp_valid_o
    |-> $past(stb_query_i || serial_poll_i))
    else $error("status answer without request");
a_poll_bit6: assert property (serial_poll_i && srq_o
    |=> status_resp_valid_o && status_resp_o[6])
    else $error("poll answer lost request bit");
a_srq_held: assert property (srq_o && !serial_poll_i |=> srq_o)
    else $error("service request dropped without poll");
a_trigger_state_query: assert property (trig_query_i |=> trigger_state_valid_o
    && trigger_state_o == $past(trigger_state_query_i))
    else $error("trigger state answer wrong");
a_pop_cause: assert property (oq_data_valid_o |-> $past(oq_rd_i))
    else $error("queue data without read");
a_read_clears: assert property (operation_summary_event_read_i && operation_summary_event_set_i == 0
    ##1 operation_summary_event_set_i == 0 |=> operation_summary_event_o == 0)
    else $error("event read did not clear");
a_seq_blocks: assert property (cmd_valid_i && cmd_ready_o && !cmd_done_i
    && cmd_i == `CMD_NONE && !cmd_parallel_i |=> !cmd_ready_o)
    else $error("sequential command did not block");
a_par_flows: assert property (cmd_valid_i && cmd_ready_o && (cmd_i ==
    `CMD_OPC || cmd_i == `CMD_NONE && cmd_parallel_i) |=> cmd_ready_o)
    else $error("parallel command blocked");
c_poll_srq: cover property (serial_poll_i && srq_o);
c_opc_query: cover property (cmd_valid_i && cmd_i == `CMD_OPCQ);
c_pop: cover property (oq_data_valid_o);
endmodule // status_byte_chk
bind status_byte_service_request status_byte_chk u_status_byte_chk (
    .clk_sys_i, .rst_i, .stb_query_i, .serial_poll_i, .operation_summary_event_read_i,
    .operation_summary_event_set_i, .cmd_i, .cmd_valid_i, .cmd_parallel_i, .cmd_done_i,
    .trigger_state_query_i, .trig_query_i, .status_resp_o, .status_resp_valid_o,
    .srq_o, .operation_summary_event_o, .oq_rd_i, .oq_data_valid_o, .cmd_ready_o,
    .trigger_state_o, .trigger_state_valid_o);

// ===== test/status_byte_service_request_tb_top.sv
// self-checking bench for the status byte and service request block
`timescale 1ns/1ps
`include "status_byte_defines.vh"
module status_byte_service_request_tb_top;
reg clk_sys_i, rst_i, ord, qrd, srd, cv, cp, cd, pb, tb, tq, rw, rd, m;
reg [15:0] oev, oen, qev, qen;
reg [7:0] sev, sen, sre, rdat, b, x;
reg [7:0] q [0:4];
reg [2:0] cmd;
reg [1:0] tst;
reg [31:0] rnd;
integer mismatches, samples_checked, i, k;
wire [7:0] sr, od, se;
wire pl, qy, sv, srq, ov, message_available, rdy, tv;
wire [15:0] oe, qe;
wire [1:0] ts;
function [31:0] lfsr(input [31:0] s);
integer j;
begin
    lfsr = s;
    for (j = 0; j < 32; j = j + 1)
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
end
endfunction
task chk(input [8*6-1:0] n, input [7:0] e, input [7:0] g);
begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
        mismatches = mismatches + 1;
        $display("unexpected %0s expected %h seen %h", n, e, g);
    end
end
endtask
task end_of_test;
begin
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
end
endtask
task tk(input integer n);
    repeat (n) @(negedge clk_sys_i);
endtask
task wait_ready;
begin
    for (k = 0; k < 20 && rdy !== 1'b1; k = k + 1)
        tk(1);
    chk("ready", 8'h01, {7'h00, rdy});
    if (rdy !== 1'b1)
        end_of_test;
end
endtask
task issue(input [2:0] c, input p);
begin
    cmd = c;
    cp = p;
    cv = 1'b1;
    tk(1);
    cv = 1'b0;
    tk(1);
end
endtask
status_byte_service_request u_status_byte_service_request (.clk_sys_i,
    .rst_i, .operation_summary_event_set_i(oev), .operation_summary_enable_i(oen),
    .operation_summary_event_read_i(ord), .ques_event_set_i(qev), .ques_enable_i(qen),
    .ques_event_read_i(qrd), .std_event_set_i(sev), .std_enable_i(sen),
    .std_event_read_i(srd), .srq_enable_i(sre), .stb_query_i(qy),
    .serial_poll_i(pl), .cmd_i(cmd), .cmd_valid_i(cv), .cmd_parallel_i(cp),
    .cmd_done_i(cd), .par_busy_i(pb), .trans_busy_i(tb), .trigger_state_query_i(tst),
    .trig_query_i(tq), .resp_wr_i(rw), .resp_data_i(rdat), .oq_rd_i(rd),
    .status_resp_o(sr), .status_resp_valid_o(sv), .srq_o(srq),
    .operation_summary_event_o(oe), .ques_event_o(qe), .std_event_o(se), .oq_data_o(od),
    .oq_data_valid_o(ov), .message_available_o(message_available), .cmd_ready_o(rdy),
    .trigger_state_o(ts), .trigger_state_valid_o(tv));
bus_ctrl_model u_bus_ctrl_model (.clk_sys_i, .status_resp_i(sr),
    .status_resp_valid_i(sv), .serial_poll_o(pl), .stb_query_o(qy));
initial
begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
end
initial
begin
    #3000000;
    mismatches = mismatches + 1;
    end_of_test;
end
initial
begin
    {ord, qrd, srd, cv, cp, cd, pb, tb, tq, rw, rd, cmd, tst} = 0;
    {oev, oen, qev, qen, sev, sen, sre, rdat} = 0;
    rst_i = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    rnd = 32'h61F0;
    tk(5);
    chk("reset", 8'h00, {srq, message_available, rdy, sv, ov, tv, ts});
    rst_i = 1'b0;
    tk(2);
    for (i = 0; i < 4; i = i + 1)
    begin
        rnd = lfsr(rnd);
        {oev, qev} = rnd;
        rnd = lfsr(rnd);
        {oen, sev, sen} = rnd;
        qen = 16'h000B;
        sre = rnd[7:0] ^ rnd[15:8];
        x = {|(oev & oen), 1'b0, |(sev & sen), 1'b0, |(qev & qen), 3'h0};
        m = |(x & sre);
        tk(1);
        {oev, qev, sev} = 0;
        tk(3);
        chk("srq", {7'h00, m}, {7'h00, srq});
        u_bus_ctrl_model.ask(1'b0, b);
        chk("query", x | {1'b0, m, 6'h00}, b);
        u_bus_ctrl_model.ask(1'b1, b);
        chk("poll", x | {1'b0, m, 6'h00}, b);
        u_bus_ctrl_model.ask(1'b1, b);
        chk("poll2", x, b);
        {ord, qrd, srd} = 3'h7;
        tk(1);
        {ord, qrd, srd} = 3'h0;
        tk(3);
        chk("evclr", 8'h00, {5'h00, |oe, |qe, |se});
        u_bus_ctrl_model.ask(1'b0, b);
        chk("clear", 8'h00, b);
    end
    $display("done groups");
    sre = 8'h00;
    rw = 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
        rnd = lfsr(rnd);
        q[i] = rnd[7:0];
        rdat = q[i];
        tk(1);
    end
    rw = 1'b0;
    tk(2);
    u_bus_ctrl_model.ask(1'b0, b);
    chk("mav", 8'h10, b);
    rd = 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
        tk(1);
        chk("oq", q[i], ov ? od : 8'hXX);
        rd = (i < 4);
    end
    rd = 1'b1;
    tk(1);
    rd = 1'b0;
    chk("empty", 8'h00, {6'h00, message_available, ov});
    $display("done queue");
    issue(`CMD_NONE, 1'b0);
    chk("seq", 8'h00, {7'h00, rdy});
    cd = 1'b1;
    tk(1);
    cd = 1'b0;
    wait_ready;
    issue(`CMD_NONE, 1'b1);
    chk("par", 8'h01, {7'h00, rdy});
    {pb, tb} = 2'h3;
    issue(`CMD_WAI, 1'b0);
    tk(3);
    chk("wait", 8'h00, {7'h00, rdy});
    pb = 1'b0;
    wait_ready;
    pb = 1'b1;
    issue(`CMD_OPC, 1'b0);
    chk("opc", 8'h01, {6'h00, se[`ESR_OPC_BIT], rdy});
    {pb, tb} = 2'h0;
    tk(4);
    chk("opcev", 8'h01, {7'h00, se[`ESR_OPC_BIT]});
    pb = 1'b1;
    issue(`CMD_OPCQ, 1'b0);
    tk(3);
    chk("opcq", 8'h00, {7'h00, message_available});
    pb = 1'b0;
    tk(4);
    rd = 1'b1;
    tk(1);
    rd = 1'b0;
    chk("opcq1", 8'h31, ov ? od : 8'hXX);
    for (i = 0; i < 3; i = i + 1)
    begin
        tst = i;
        tq = 1'b1;
        tk(1);
        tq = 1'b0;
        chk("trig", {6'h00, tst}, tv ? {6'h00, ts} : 8'hXX);
    end
    $display("done commands");
    // a pending byte raises the request, then a mid-run reset drops all
    sre = 8'h10;
    sen = 8'h00;
    rw = 1'b1;
    rdat = 8'hA5;
    tk(1);
    rw = 1'b0;
    tk(3);
    u_bus_ctrl_model.ask(1'b0, b);
    chk("mss", 8'h50, b);
    chk("srqon", 8'h03, {6'h00, srq, message_available});
    rst_i = 1'b1;
    tk(2);
    chk("rst2", 8'h00, {srq, message_available, rdy, sv, ov, tv, ts});
    rst_i = 1'b0;
    tk(2);
    chk("rstq", 8'h01, {5'h00, srq, message_available, rdy});
    $display("done reset");
    end_of_test;
end
endmodule // status_byte_service_request_tb_top
